// ### hdl/pdp_map.svh
// Constants of the PHY data port: symbol values and codes
`ifndef PDP_MAP_SVH
`define PDP_MAP_SVH

`define PDP_PRE_NIB 4'h5
`define PDP_SFD_LO_NIB 4'hD
`define PDP_ERR_NIB 4'hE
`define PDP_IDLE_NIB 4'h0
`define PDP_IDLE_DIBIT 2'h0
`define PDP_H_CODE 5'h04
`define PDP_NO_CODE 5'h00

`endif

// ### hdl/pdp_pkg.sv
// Types and the 4B/5B table of the PHY data port
package pdp_pkg;

    typedef enum logic [2:0] {
        SYM_DATA = 3'b000,
        SYM_IDLE = 3'b001,
        SYM_JK = 3'b010,
        SYM_TR = 3'b011,
        SYM_ERR = 3'b100
    } pdp_sym_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_PRE = 2'b01,
        RX_DATA = 2'b10
    } pdp_rx_st_e;

    typedef struct packed {
        logic valid;
        pdp_sym_e kind;
        logic [3:0] nib;
    } pdp_line_rx_s;

    typedef struct packed {
        logic crs;
        logic dv;
        logic er;
        logic [3:0] nib;
    } pdp_nib_s;

    typedef struct packed {
        logic speed100;
        logic full_duplex;
        logic link_up;
        logic an_enable;
    } pdp_cfg_s;

    function automatic logic [4:0] pdp_enc_4b5b(input logic [3:0] nib);
        logic [4:0] code;
        code = 5'h1E;
        unique case (nib)
            4'h0: code = 5'h1E;
            4'h1: code = 5'h09;
            4'h2: code = 5'h14;
            4'h3: code = 5'h15;
            4'h4: code = 5'h0A;
            4'h5: code = 5'h0B;
            4'h6: code = 5'h0E;
            4'h7: code = 5'h0F;
            4'h8: code = 5'h12;
            4'h9: code = 5'h13;
            4'hA: code = 5'h16;
            4'hB: code = 5'h17;
            4'hC: code = 5'h1A;
            4'hD: code = 5'h1B;
            4'hE: code = 5'h1C;
            4'hF: code = 5'h1D;
        endcase
        return code;
    endfunction

endpackage

// ### hdl/pdp_data_port.sv
// PHY-side MII / reduced MII data port with line-clock receive framing
`timescale 1ns/1ns
`include "pdp_map.svh"

module pdp_data_port (
    input wire logic clock,
    input wire logic rst,
    input wire logic line_clock,
    input wire logic rmii_strap,
    input wire pdp_pkg::pdp_cfg_s cfg,
    input wire pdp_pkg::pdp_line_rx_s line_rx,
    input wire logic line_squelch_ok,
    input wire logic [3:0] mii_txd,
    input wire logic mii_txen,
    input wire logic mii_txer,
    input wire logic [1:0] rmii_txd,
    input wire logic rmii_txen,
    output logic [3:0] mii_rxd,
    output logic mii_rxdv,
    output logic mii_rxer,
    output logic mii_crs,
    output logic mii_col,
    output logic recv_clock_out,
    output logic xmit_clock_out,
    output logic recv_clk_from_line,
    output logic rmii_crs_dv,
    output logic [1:0] rmii_rxd,
    output logic rmii_rx_er,
    output logic [4:0] tx_code,
    output logic tx_code_valid,
    output logic rmii_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Line domain: reset and speed brought over from the core clock

    logic lrst_q1;
    logic lrst_q2;
    logic [2:0] spd_q;
    logic spd100_l;

    always_ff @(posedge line_clock) begin
        lrst_q1 <= rst;
        lrst_q2 <= lrst_q1;
    end

    always_ff @(posedge line_clock) begin
        spd_q <= {spd_q[1:0], cfg.speed100};
        if (spd_q[1] == spd_q[2]) begin
            spd100_l <= spd_q[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line domain: receive framing per symbol

    pdp_pkg::pdp_rx_st_e st_r;
    pdp_pkg::pdp_rx_st_e st_nxt;
    pdp_pkg::pdp_nib_s evt_r;
    pdp_pkg::pdp_nib_s evt_nxt;
    logic fire;
    logic tgl_r;

    wire is_data = line_rx.kind == pdp_pkg::SYM_DATA;
    wire is_pre = is_data && line_rx.nib == `PDP_PRE_NIB;
    wire is_sfd = is_data && line_rx.nib == `PDP_SFD_LO_NIB;
    wire eof_10 = !spd100_l && (!line_squelch_ok || line_rx.kind == pdp_pkg::SYM_TR);

    always_comb begin
        st_nxt = st_r;
        evt_nxt = evt_r;
        evt_nxt.er = 1'b0;
        fire = 1'b0;
        if (line_rx.valid) begin
            fire = 1'b1;
            unique case (st_r)
                pdp_pkg::RX_IDLE: begin
                    if (spd100_l && line_rx.kind == pdp_pkg::SYM_JK) begin
                        st_nxt = pdp_pkg::RX_DATA;
                        evt_nxt.crs = 1'b1;
                        evt_nxt.dv = 1'b1;
                        evt_nxt.nib = `PDP_PRE_NIB;
                    end else if (!spd100_l && line_squelch_ok && is_pre) begin
                        st_nxt = pdp_pkg::RX_PRE;
                        evt_nxt.crs = 1'b1;
                        evt_nxt.dv = 1'b0;
                        evt_nxt.nib = `PDP_IDLE_NIB;
                    end else begin
                        fire = 1'b0;
                    end
                end
                pdp_pkg::RX_PRE: begin
                    if (eof_10) begin
                        st_nxt = pdp_pkg::RX_IDLE;
                        evt_nxt.crs = 1'b0;
                        evt_nxt.dv = 1'b0;
                        evt_nxt.nib = `PDP_IDLE_NIB;
                    end else if (is_sfd) begin
                        st_nxt = pdp_pkg::RX_DATA;
                        evt_nxt.dv = 1'b1;
                        evt_nxt.nib = line_rx.nib;
                    end else if (line_rx.kind == pdp_pkg::SYM_ERR) begin
                        evt_nxt.er = 1'b1;
                        evt_nxt.nib = `PDP_ERR_NIB;
                    end else begin
                        fire = 1'b0;
                    end
                end
                pdp_pkg::RX_DATA: begin
                    if (eof_10) begin
                        st_nxt = pdp_pkg::RX_IDLE;
                        evt_nxt.crs = 1'b0;
                        evt_nxt.dv = 1'b0;
                        evt_nxt.nib = `PDP_IDLE_NIB;
                    end else begin
                        unique case (line_rx.kind)
                            pdp_pkg::SYM_DATA, pdp_pkg::SYM_JK: begin
                                evt_nxt.nib = line_rx.nib;
                            end
                            pdp_pkg::SYM_TR: begin
                                st_nxt = pdp_pkg::RX_IDLE;
                                evt_nxt.crs = 1'b0;
                                evt_nxt.dv = 1'b0;
                                evt_nxt.nib = `PDP_IDLE_NIB;
                            end
                            pdp_pkg::SYM_IDLE: begin
                                st_nxt = pdp_pkg::RX_IDLE;
                                evt_nxt.crs = 1'b0;
                                evt_nxt.dv = 1'b0;
                                evt_nxt.er = 1'b1;
                                evt_nxt.nib = `PDP_IDLE_NIB;
                            end
                            pdp_pkg::SYM_ERR: begin
                                evt_nxt.er = 1'b1;
                                evt_nxt.nib = `PDP_ERR_NIB;
                            end
                            default: begin
                                fire = 1'b0;
                            end
                        endcase
                    end
                end
                default: begin
                    st_nxt = pdp_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // Word stays put between toggles, so the core reads it once the toggle settles
    always_ff @(posedge line_clock) begin
        if (lrst_q2) begin
            st_r <= pdp_pkg::RX_IDLE;
            evt_r <= '0;
            tgl_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (fire) begin
                evt_r <= evt_nxt;
                tgl_r <= ~tgl_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: synchronisers for the strap and the event toggle

    wire [1:0] async_in = {tgl_r, rmii_strap};
    logic [1:0] sq1;
    logic [1:0] sq2;
    logic [1:0] sq3;
    logic [1:0] sval_r;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clock) begin
                sq1[g] <= async_in[g];
                sq2[g] <= sq1[g];
                sq3[g] <= sq2[g];
                if (rst) begin
                    sval_r[g] <= 1'b0;
                end else if (sq2[g] == sq3[g]) begin
                    sval_r[g] <= sq3[g];
                end
            end
        end
    endgenerate

    // Strap is caught while reset is held
    always_ff @(posedge clock) begin
        if (rst && sq2[0] == sq3[0]) begin
            rmii_mode <= sq3[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain: receive word hand-over and pacing

    logic seen_r;
    logic pend_r;
    logic rph_r;
    pdp_pkg::pdp_nib_s cur_r;

    wire evt_new = sval_r[1] ^ seen_r;
    wire mii_upd = !rmii_mode && recv_clock_out;
    wire mii_smp = !rmii_mode && !xmit_clock_out;
    wire consume = mii_upd || (rmii_mode && pend_r && rph_r);
    wire line_src = cfg.speed100 ? (cfg.link_up || cfg.an_enable) : cur_r.crs;
    wire [3:0] mii_rxd_sel = (cur_r.dv || cur_r.er) ? cur_r.nib : `PDP_IDLE_NIB;
    wire [1:0] rdibit = rph_r ? cur_r.nib[3:2] : cur_r.nib[1:0];
    wire rx_dec_ok = rmii_crs_dv && cur_r.dv && pend_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            seen_r <= 1'b0;
            cur_r <= '0;
            pend_r <= 1'b0;
        end else begin
            seen_r <= sval_r[1];
            if (evt_new) begin
                cur_r <= evt_r;
            end
            if (evt_new) begin
                pend_r <= 1'b1;
            end else if (consume) begin
                pend_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // MII receive side, clocks generated from the master clock

    always_ff @(posedge clock) begin
        if (rst) begin
            recv_clock_out <= 1'b0;
            xmit_clock_out <= 1'b0;
            recv_clk_from_line <= 1'b0;
        end else begin
            recv_clock_out <= ~recv_clock_out;
            xmit_clock_out <= ~xmit_clock_out;
            recv_clk_from_line <= !rmii_mode && line_src;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mii_rxd <= `PDP_IDLE_NIB;
            mii_rxdv <= 1'b0;
            mii_rxer <= 1'b0;
            mii_crs <= 1'b0;
        end else if (mii_upd) begin
            mii_rxd <= mii_rxd_sel;
            mii_rxdv <= cur_r.dv;
            mii_rxer <= cur_r.er && pend_r;
            mii_crs <= cur_r.crs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reduced MII receive side

    always_ff @(posedge clock) begin
        if (rst || !rmii_mode) begin
            rmii_crs_dv <= 1'b0;
            rmii_rxd <= `PDP_IDLE_DIBIT;
            rmii_rx_er <= 1'b0;
            rph_r <= 1'b0;
        end else begin
            rmii_crs_dv <= cur_r.crs;
            rmii_rxd <= rx_dec_ok ? rdibit : `PDP_IDLE_DIBIT;
            rmii_rx_er <= cur_r.er && pend_r;
            rph_r <= pend_r ? ~rph_r : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit side toward the line coder

    logic tph_r;
    logic [1:0] tlo_r;
    logic tx_active_r;

    wire [3:0] tx_nib = rmii_mode ? {rmii_txd, tlo_r} : mii_txd;
    wire tx_err = !rmii_mode && mii_txer;
    wire [4:0] tx_enc = tx_err ? `PDP_H_CODE : pdp_pkg::pdp_enc_4b5b(tx_nib);
    wire tx_take = rmii_mode ? (rmii_txen && tph_r) : (mii_smp && mii_txen);
    wire tx_on = rmii_mode ? rmii_txen : (mii_smp ? mii_txen : tx_active_r);

    always_ff @(posedge clock) begin
        if (rst) begin
            tph_r <= 1'b0;
            tlo_r <= `PDP_IDLE_DIBIT;
            tx_code <= `PDP_NO_CODE;
            tx_code_valid <= 1'b0;
            tx_active_r <= 1'b0;
        end else begin
            tph_r <= rmii_mode && rmii_txen && !tph_r;
            if (rmii_mode && rmii_txen && !tph_r) begin
                tlo_r <= rmii_txd;
            end
            tx_code_valid <= tx_take;
            tx_code <= tx_take ? tx_enc : `PDP_NO_CODE;
            tx_active_r <= tx_on;
        end
    end

    // Collision only on the four-bit interface; reduced mode has no pin for it
    always_ff @(posedge clock) begin
        if (rst) begin
            mii_col <= 1'b0;
        end else begin
            mii_col <= !rmii_mode && !cfg.full_duplex && tx_active_r && cur_r.crs;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_pre_dv;
        @(posedge line_clock) disable iff (lrst_q2)
        spd100_l && st_r == pdp_pkg::RX_IDLE && line_rx.valid && line_rx.kind == pdp_pkg::SYM_JK
        |=> evt_r.dv && evt_r.crs && evt_r.nib == `PDP_PRE_NIB;
    endproperty
    a_pre_dv: assert property (p_pre_dv) else $error("preamble did not raise valid");

    property p_sfd_dv;
        @(posedge line_clock) disable iff (lrst_q2)
        !spd100_l && st_r == pdp_pkg::RX_PRE && line_rx.valid && is_sfd && line_squelch_ok
        |=> evt_r.dv && st_r == pdp_pkg::RX_DATA;
    endproperty
    a_sfd_dv: assert property (p_sfd_dv) else $error("delimiter did not raise valid");

    property p_rx_fall;
        @(posedge clock) disable iff (rst)
        !rmii_mode && !$stable(mii_rxd) |-> $fell(recv_clock_out);
    endproperty
    a_rx_fall: assert property (p_rx_fall) else $error("receive data moved off falling edge");

    property p_er_pulse;
        @(posedge clock) disable iff (rst)
        $fell(mii_crs) && mii_rxer |=> mii_rxer ##1 !mii_rxer;
    endproperty
    a_er_pulse: assert property (p_er_pulse) else $error("error pulse not one receive clock");

    property p_rxd_hold;
        @(posedge clock) disable iff (rst)
        rmii_mode && $rose(rmii_crs_dv) |-> rmii_rxd == `PDP_IDLE_DIBIT;
    endproperty
    a_rxd_hold: assert property (p_rxd_hold) else $error("dibits not 00 at carrier rise");

    property p_rxd_idle;
        @(posedge clock) disable iff (rst)
        rmii_mode && !rmii_crs_dv ##1 !rmii_crs_dv |-> rmii_rxd == `PDP_IDLE_DIBIT;
    endproperty
    a_rxd_idle: assert property (p_rxd_idle) else $error("dibits not idle without carrier");

    property p_tx_rise;
        @(posedge clock) disable iff (rst)
        !rmii_mode && tx_code_valid |-> $rose(xmit_clock_out);
    endproperty
    a_tx_rise: assert property (p_tx_rise) else $error("transmit sample off rising edge");

    property p_h_code;
        @(posedge clock) disable iff (rst)
        !rmii_mode && !xmit_clock_out && mii_txen && mii_txer
        |=> tx_code_valid && tx_code == `PDP_H_CODE;
    endproperty
    a_h_code: assert property (p_h_code) else $error("transmit error not sent as H");

    property p_tx_ignore;
        @(posedge clock) disable iff (rst)
        rmii_mode && !rmii_txen |=> !tx_code_valid;
    endproperty
    a_tx_ignore: assert property (p_tx_ignore) else $error("dibits taken without enable");

    property p_col;
        @(posedge clock) disable iff (rst)
        !rmii_mode && !cfg.full_duplex && tx_active_r && cur_r.crs |=> mii_col;
    endproperty
    a_col: assert property (p_col) else $error("collision not raised");

    property p_no_sqe;
        @(posedge clock) disable iff (rst)
        rmii_mode |=> !mii_col;
    endproperty
    a_no_sqe: assert property (p_no_sqe) else $error("collision pulse in reduced mode");

    c_rmii_frame: cover property (@(posedge clock) disable iff (rst)
        rmii_mode && $rose(rmii_crs_dv));
    c_mii_col: cover property (@(posedge clock) disable iff (rst) $rose(mii_col));
    c_h_sent: cover property (@(posedge clock) disable iff (rst)
        tx_code_valid && tx_code == `PDP_H_CODE);
    c_rx_err: cover property (@(posedge clock) disable iff (rst) $rose(mii_rxer));

endmodule // pdp_data_port

// ### tb/pdp_mac_model.sv
// Controller-side model driving the MII and reduced transmit inputs
`timescale 1ns/1ns

module pdp_mac_model (
    input wire logic clock,
    input wire logic xmit_clock_out,
    input wire logic rmii_crs_dv,
    output logic [3:0] mii_txd,
    output logic mii_txen,
    output logic mii_txer,
    output logic [1:0] rmii_txd,
    output logic rmii_txen,
    output logic rmii_col
);
    initial begin
        mii_txd = 4'h0;
        mii_txen = 1'b0;
        mii_txer = 1'b0;
        rmii_txd = 2'h0;
        rmii_txen = 1'b0;
    end

    assign rmii_col = rmii_txen & rmii_crs_dv;

    // Launch just after the transmit clock rises so the next rise takes it
    task automatic mii_nib(input logic [3:0] n, input logic en, input logic er);
        @(posedge clock);
        #2;
        if (xmit_clock_out !== 1'b1) begin
            @(posedge clock);
            #2;
        end
        mii_txd = n;
        mii_txen = en;
        mii_txer = er;
    endtask

    task automatic rmii_dibit(input logic [1:0] d, input logic en);
        @(posedge clock);
        #2;
        rmii_txd = d;
        rmii_txen = en;
    endtask
endmodule // pdp_mac_model

// ### tb/tb_top.sv
// Self-checking bench for the PHY data port
`timescale 1ns/1ns

module tb_top;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic clock = 1'b0;
    logic line_clock = 1'b0;
    logic rst = 1'b1;
    logic rmii_strap = 1'b0;
    logic line_squelch_ok = 1'b0;
    pdp_pkg::pdp_cfg_s cfg = 4'hB;
    pdp_pkg::pdp_line_rx_s line_rx = '0;
    logic [3:0] mii_txd;
    logic mii_txen;
    logic mii_txer;
    logic [1:0] rmii_txd;
    logic rmii_txen;
    logic [3:0] mii_rxd;
    logic mii_rxdv;
    logic mii_rxer;
    logic mii_crs;
    logic mii_col;
    logic recv_clock_out;
    logic xmit_clock_out;
    logic recv_clk_from_line;
    logic rmii_crs_dv;
    logic [1:0] rmii_rxd;
    logic rmii_rx_er;
    logic [4:0] tx_code;
    logic tx_code_valid;
    logic rmii_mode;
    int mismatches = 0;
    int comparisons = 0;
    integer seed = 42;
    logic [6:0] rx_q [$];
    logic [4:0] tx_q [$];
    logic [6:0] rx_last = '0;
    logic dv_prev = 1'b0;
    logic [2:0] seen = '0;
    wire [6:0] rx_now = {mii_crs, mii_rxdv, mii_rxer, mii_rxdv ? mii_rxd : 4'h0};

    always #10 clock = ~clock;
    always begin
        #62 line_clock = 1'b1;
        #63 line_clock = 1'b0;
    end

    pdp_data_port pdp_data_port_inst (.clock(clock), .rst(rst), .line_clock(line_clock),
        .rmii_strap(rmii_strap), .cfg(cfg), .line_rx(line_rx), .line_squelch_ok(line_squelch_ok),
        .mii_txd(mii_txd), .mii_txen(mii_txen), .mii_txer(mii_txer), .rmii_txd(rmii_txd),
        .rmii_txen(rmii_txen), .mii_rxd(mii_rxd), .mii_rxdv(mii_rxdv), .mii_rxer(mii_rxer),
        .mii_crs(mii_crs), .mii_col(mii_col), .recv_clock_out(recv_clock_out),
        .xmit_clock_out(xmit_clock_out), .recv_clk_from_line(recv_clk_from_line),
        .rmii_crs_dv(rmii_crs_dv), .rmii_rxd(rmii_rxd), .rmii_rx_er(rmii_rx_er),
        .tx_code(tx_code), .tx_code_valid(tx_code_valid), .rmii_mode(rmii_mode));

    pdp_mac_model pdp_mac_model_inst (.clock(clock), .xmit_clock_out(xmit_clock_out),
        .rmii_crs_dv(rmii_crs_dv), .mii_txd(mii_txd), .mii_txen(mii_txen), .mii_txer(mii_txer),
        .rmii_txd(rmii_txd), .rmii_txen(rmii_txen), .rmii_col());

    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Mismatches %0d, comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fail_cmp(input logic [7:0] exp, input logic [7:0] got);
        mismatches++;
        $display("ERROR at %0t: expected %0h, got %0h", $time, exp, got);
    endtask

    task automatic check_rx(input logic [6:0] exp, input logic [6:0] got);
        comparisons++;
        if (got !== exp) fail_cmp({1'b0, exp}, {1'b0, got});
    endtask

    task automatic check_tx(input logic [4:0] exp, input logic [4:0] got);
        comparisons++;
        if (got !== exp) fail_cmp({3'h0, exp}, {3'h0, got});
    endtask

    task automatic check_flag(input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) fail_cmp({6'h00, exp}, {6'h00, got});
    endtask

    task automatic settle();
        repeat (4) @(posedge clock);
        #2;
    endtask

    task automatic do_reset(input logic strap);
        rst = 1'b1;
        rmii_strap = strap;
        repeat (6) @(posedge clock);
        repeat (3) @(posedge line_clock);
        @(posedge clock);
        #2;
        rst = 1'b0;
        check_flag({1'b0, strap}, {1'b0, rmii_mode});
        repeat (3) @(posedge line_clock);
    endtask

    // Wait for every noted result to appear, with a bound
    task automatic drain();
        int k;
        k = 0;
        while ((rx_q.size() != 0 || tx_q.size() != 0) && k < 500) begin
            @(posedge clock);
            k++;
        end
        if (rx_q.size() + tx_q.size() != 0) begin
            fail_cmp(8'h00, 8'(rx_q.size() + tx_q.size()));
            stop_test();
        end
        repeat (20) @(posedge clock);
        #2;
    endtask

    task automatic line_sym(input logic v, input logic [2:0] k, input logic [3:0] n);
        @(posedge line_clock);
        #2;
        line_rx = {v, k, n};
    endtask

    task automatic send_frame(input logic [6:0] s [$]);
        foreach (s[i]) line_sym(1'b1, s[i][6:4], s[i][3:0]);
        line_sym(1'b0, 3'h1, 4'h0);
    endtask

    task automatic mii_burst(input int cnt, input logic en);
        logic [3:0] n;
        logic er;
        for (int i = 0; i < cnt; i++) begin
            n = 4'($random(seed));
            er = en && (i == 3);
            if (en) tx_q.push_back(er ? 5'h04 : ENC[n]);
            pdp_mac_model_inst.mii_nib(n, en, er);
        end
        pdp_mac_model_inst.mii_nib(4'h0, 1'b0, 1'b0);
    endtask

    task automatic rmii_burst(input int cnt, input logic en);
        logic [3:0] n;
        for (int i = 0; i < cnt; i++) begin
            n = 4'($random(seed));
            if (en) tx_q.push_back(ENC[n]);
            pdp_mac_model_inst.rmii_dibit(n[1:0], en);
            pdp_mac_model_inst.rmii_dibit(n[3:2], en);
        end
        pdp_mac_model_inst.rmii_dibit(2'h0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge recv_clock_out) begin
        if (rst === 1'b0 && rx_now !== rx_last) begin
            rx_last = rx_now;
            check_rx(rx_q.size() != 0 ? rx_q.pop_front() : 'x, rx_now);
        end
    end

    always @(posedge clock) begin
        if (rst === 1'b0) begin
            if (tx_code_valid === 1'b1) check_tx(tx_q.size() != 0 ? tx_q.pop_front() : 'x, tx_code);
            if (rmii_mode === 1'b1) begin
                if (!(rmii_crs_dv === 1'b1 && dv_prev === 1'b1)) check_flag(2'h0, rmii_rxd);
                seen = seen | {mii_col, rmii_rx_er, rmii_crs_dv === 1'b1 && rmii_rxd === 2'h3};
            end
            dv_prev = rmii_crs_dv;
        end
    end

    initial begin
        do_reset(1'b0);
        check_flag(2'h1, {1'b0, recv_clk_from_line});
        rx_q = '{7'h65, 7'h63, 7'h7E, 7'h6E, 7'h67, 7'h00};
        fork
            send_frame('{7'h25, 7'h03, 7'h40, 7'h07, 7'h30});
            mii_burst(14, 1'b1);
            begin
                #400;
                check_flag(2'h1, {1'b0, mii_col});
            end
        join
        drain();
        rx_q = '{7'h65, 7'h69, 7'h10, 7'h00};
        send_frame('{7'h25, 7'h09, 7'h10});
        drain();
        cfg = 4'h9;
        settle();
        check_flag(2'h1, {1'b0, recv_clk_from_line});
        cfg = 4'h8;
        settle();
        check_flag(2'h0, {1'b0, recv_clk_from_line});
        cfg = 4'h3;
        settle();
        check_flag(2'h0, {1'b0, recv_clk_from_line});
        @(posedge line_clock);
        #2;
        line_squelch_ok = 1'b1;
        rx_q = '{7'h40, 7'h6D, 7'h62, 7'h00};
        fork
            send_frame('{7'h05, 7'h05, 7'h05, 7'h05, 7'h0D, 7'h02, 7'h30});
            mii_burst(6, 1'b0);
            begin
                #800;
                check_flag(2'h1, {1'b0, recv_clk_from_line});
            end
        join
        @(posedge line_clock);
        #2;
        line_squelch_ok = 1'b0;
        drain();
        cfg = 4'hB;
        do_reset(1'b1);
        fork
            send_frame('{7'h25, 7'h0F, 7'h40, 7'h0F, 7'h30});
            rmii_burst(12, 1'b1);
        join
        rmii_burst(6, 1'b0);
        drain();
        check_flag(2'h3, seen[1:0]);
        check_flag(2'h0, {1'b0, seen[2]});
        stop_test();
    end
endmodule // tb_top
